// ### core/cbo_agen.sv
// effective address, block alignment and final operation choice
`timescale 1ns/1ps
`default_nettype none
`include "cbo_defines.svh"

module cbo_agen
    import cbo_pkg::*;
#(
    parameter int XLEN = `CBO_XLEN,
    parameter int BLOCK_BYTES = `CBO_BLOCK_BYTES
) (
    cbo_ea_if.agen ea
);
    localparam int OFF_W = $clog2(BLOCK_BYTES);

    function automatic logic is_flush_code(input logic [`CBO_INVB_W-1:0] f);
        return f == `CBO_INVB_FLUSH;
    endfunction

    wire logic is_pf;
    wire logic pf_ok;
    wire logic inval_as_flush;
    wire logic [`CBO_IMM_W-1:0] imm;
    wire logic [XLEN-1:0] imm_sext;
    wire logic [XLEN-1:0] eff_addr;

    assign is_pf = (ea.op == CBO_PF_I) || (ea.op == CBO_PF_R) || (ea.op == CBO_PF_W);
    // the destination field only names a prefetch when it is zero, and then doubles as imm[4:0]
    assign pf_ok = (ea.rd == `CBO_RD_ZERO); // RL16
    assign imm = {ea.imm_hi, ea.rd}; // RL16
    assign imm_sext = {{(XLEN-`CBO_IMM_W){imm[`CBO_IMM_W-1]}}, imm}; // RL9
    // maintenance and zero take the base alone; any offset is ignored
    assign eff_addr = is_pf ? ea.base + imm_sext : ea.base; // RL1 RL9
    assign ea.blk_addr = {eff_addr[XLEN-1:OFF_W], {OFF_W{1'b0}}}; // RL17

    assign inval_as_flush =
        ((ea.priv != CBO_PRIV_M) && is_flush_code(ea.menv_invb)) ||
        ((ea.priv == CBO_PRIV_U) && is_flush_code(ea.senv_invb)) ||
        ((ea.priv == CBO_PRIV_VS) && is_flush_code(ea.henv_invb)) ||
        ((ea.priv == CBO_PRIV_VU) && (is_flush_code(ea.henv_invb) || is_flush_code(ea.senv_invb))); // RL6 RL13

    assign ea.eff_op = (ea.op == CBO_INVAL && inval_as_flush) ? CBO_FLUSH : // RL13
                       (is_pf && !pf_ok) ? CBO_NOP : ea.op;
endmodule // cbo_agen

`default_nettype wire

// ### core/cbo_beat_ctr.sv
// word beat counter that walks a cache block during zeroing
`timescale 1ns/1ps
`default_nettype none

module cbo_beat_ctr #(
    parameter int BEATS = 8,
    parameter int IW = (BEATS > 1) ? $clog2(BEATS) : 1
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic en_i,
    // control
    input wire logic clr_i,
    input wire logic step_i,
    // state
    output logic [IW-1:0] idx_o,
    output logic last_o
);
    logic [IW-1:0] idx_reg;
    logic [IW-1:0] idx_next;

    assign idx_next = clr_i ? '0 : (step_i ? idx_reg + 1'b1 : idx_reg);
    assign idx_o = idx_reg;
    assign last_o = (idx_reg == IW'(BEATS - 1));

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idx_reg <= '0;
        end else if (en_i) begin
            idx_reg <= idx_next;
        end
    end
endmodule // cbo_beat_ctr

`default_nettype wire

// ### core/cbo_unit.sv
// cache block maintenance, zero and prefetch sequencer
// Operation
// RL1: clean acts on the block at the base register address, no offset added.
// RL2: software gives clean, flush, invalidate or zero no offset, or a zero one.
// RL3: maintenance acts on the coherent caches that the issuing agent uses.
// RL4: flush acts on the block at the base register address.
// RL5: invalidate acts on the block at the base register address.
// RL6: configuration can turn an invalidate into a flush of that block.
// RL7: zero writes zero to every byte of the addressed block.
// RL8: zeroing need not be atomic; piecewise updates are allowed.
// RL9: prefetch address is base plus sign-extended 12-bit immediate, low five zero.
// RL10: instruction prefetch may load the block into the fetch cache, optionally.
// RL11: read prefetch may bring the block into the data-read cache, optionally.
// RL12: write prefetch may bring the block into the data-write cache, optionally.
// RL13: behaviour field value 01 makes invalidate perform a flush.
// RL14: flush is an atomic clean followed by invalidate of the same block.
// RL15: clean writes back only if the block was modified since last maintenance.
// RL16: prefetch needs destination field zero; it then serves as imm[4:0].
// RL17: every effective address is aligned down to the block boundary.
`timescale 1ns/1ps
`default_nettype none
`include "cbo_defines.svh"

module cbo_unit
    import cbo_pkg::*;
#(
    parameter int XLEN = `CBO_XLEN,
    parameter int BLOCK_BYTES = `CBO_BLOCK_BYTES,
    parameter int WORD_BYTES = `CBO_WORD_BYTES,
    parameter bit PREFETCH_EN = 1'b1
) (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic en_i,
    // request from the pipeline
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire cbo_op_t req_op_i,
    input wire logic [XLEN-1:0] req_base_i,
    input wire logic [`CBO_IMM_HI_W-1:0] req_imm_hi_i,
    input wire logic [`CBO_IMM_LO_W-1:0] req_rd_i,
    input wire cbo_priv_t req_priv_i,
    // invalidate behaviour fields of the environment configuration
    input wire logic [`CBO_INVB_W-1:0] menv_invalidate_behaviour_field_i,
    input wire logic [`CBO_INVB_W-1:0] senv_invalidate_behaviour_field_i,
    input wire logic [`CBO_INVB_W-1:0] henv_invalidate_behaviour_field_i,
    // completion to the pipeline
    output logic done_o,
    output cbo_op_t done_op_o,
    output logic [XLEN-1:0] done_addr_o,
    output logic done_wb_o,
    // coherent cache hierarchy of this agent
    output logic cache_cmd_valid_o,
    input wire logic cache_cmd_ready_i,
    output cbo_cmd_t cache_cmd_o,
    output logic [XLEN-1:0] cache_addr_o,
    output logic cache_lock_o,
    input wire logic cache_ack_i,
    input wire logic cache_dirty_i
);
    localparam int BEATS = BLOCK_BYTES / WORD_BYTES;
    localparam int IW = (BEATS > 1) ? $clog2(BEATS) : 1;
    localparam int WOFF = $clog2(WORD_BYTES);

    generate
        if (XLEN != 32 && XLEN != 64) begin : g_bad_xlen
            $error("cbo_unit: XLEN must be 32 or 64");
        end
        if ((BLOCK_BYTES & (BLOCK_BYTES - 1)) != 0 || (WORD_BYTES & (WORD_BYTES - 1)) != 0 ||
            WORD_BYTES > BLOCK_BYTES || BLOCK_BYTES < 32 || BLOCK_BYTES > 4096) begin : g_bad_geom
            $error("cbo_unit: block and word sizes must be powers of two, 32 <= block <= 4096");
        end
    endgenerate

    typedef enum logic [1:0] {
        CBO_ST_IDLE,
        CBO_ST_ISSUE,
        CBO_ST_WAIT,
        CBO_ST_DONE
    } cbo_state_t;

    cbo_state_t state_reg;
    cbo_state_t state_next;
    cbo_op_t op_reg;
    cbo_op_t op_next;
    cbo_cmd_t cmd_reg;
    cbo_cmd_t cmd_next;
    logic [XLEN-1:0] blk_reg;
    logic [XLEN-1:0] blk_next;
    logic [XLEN-1:0] addr_reg;
    logic [XLEN-1:0] addr_next;
    logic wb_reg;
    logic wb_next;

    wire logic accept;
    wire logic issued;
    wire logic acked;
    wire logic [IW-1:0] beat_idx;
    wire logic beat_last;
    wire logic [XLEN-1:0] beat_off;
    wire cbo_cmd_t first_cmd;
    wire logic first_none;
    wire cbo_cmd_t after_clean_cmd;
    wire logic after_clean_done;

    cbo_ea_if #(.XLEN(XLEN)) ea_bus ();

    assign ea_bus.op = req_op_i;
    assign ea_bus.base = req_base_i;
    assign ea_bus.imm_hi = req_imm_hi_i;
    assign ea_bus.rd = req_rd_i;
    assign ea_bus.priv = req_priv_i;
    assign ea_bus.menv_invb = menv_invalidate_behaviour_field_i;
    assign ea_bus.senv_invb = senv_invalidate_behaviour_field_i;
    assign ea_bus.henv_invb = henv_invalidate_behaviour_field_i;

    cbo_agen #(
        .XLEN(XLEN),
        .BLOCK_BYTES(BLOCK_BYTES)
    ) u_agen (
        .ea(ea_bus)
    );

    cbo_beat_ctr #(
        .BEATS(BEATS),
        .IW(IW)
    ) u_beat (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .en_i(en_i),
        .clr_i(accept),
        .step_i(acked && cmd_reg == CBO_CMD_ZERO),
        .idx_o(beat_idx),
        .last_o(beat_last)
    );

    assign req_ready_o = (state_reg == CBO_ST_IDLE);
    assign accept = en_i && req_valid_i && req_ready_o;
    assign issued = en_i && (state_reg == CBO_ST_ISSUE) && cache_cmd_ready_i;
    assign acked = en_i && (state_reg == CBO_ST_WAIT) && cache_ack_i;
    assign beat_off = XLEN'(beat_idx) << WOFF;

    // clean and flush start by probing for modified data; a plain invalidate goes straight in
    assign first_cmd = (ea_bus.eff_op == CBO_CLEAN) ? CBO_CMD_PROBE : // RL1
                       (ea_bus.eff_op == CBO_FLUSH) ? CBO_CMD_PROBE : // RL4 RL14
                       (ea_bus.eff_op == CBO_INVAL) ? CBO_CMD_INVAL : // RL5
                       (ea_bus.eff_op == CBO_ZERO) ? CBO_CMD_ZERO : // RL7
                       (ea_bus.eff_op == CBO_PF_I) ? CBO_CMD_FILL_I : // RL10
                       (ea_bus.eff_op == CBO_PF_R) ? CBO_CMD_FILL_R : // RL11
                       CBO_CMD_FILL_W; // RL12
    // prefetches are hints: with fills disabled they retire without touching the caches
    assign first_none = (ea_bus.eff_op == CBO_NOP) ||
                        (!PREFETCH_EN && ea_bus.eff_op inside {CBO_PF_I, CBO_PF_R, CBO_PF_W});

    // after the clean part, flush continues with the invalidate of the same block
    assign after_clean_cmd = CBO_CMD_INVAL; // RL14
    assign after_clean_done = (op_reg != CBO_FLUSH);

    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        cmd_next = cmd_reg;
        blk_next = blk_reg;
        addr_next = addr_reg;
        wb_next = wb_reg;
        case (state_reg)
            CBO_ST_IDLE: begin
                if (accept) begin
                    op_next = ea_bus.eff_op;
                    blk_next = ea_bus.blk_addr; // RL17
                    addr_next = ea_bus.blk_addr;
                    cmd_next = first_cmd;
                    wb_next = 1'b0;
                    state_next = first_none ? CBO_ST_DONE : CBO_ST_ISSUE;
                end
            end
            CBO_ST_ISSUE: begin
                if (issued) begin
                    state_next = CBO_ST_WAIT;
                end
            end
            CBO_ST_WAIT: begin
                if (acked) begin
                    state_next = CBO_ST_ISSUE;
                    case (cmd_reg)
                        CBO_CMD_PROBE: begin
                            // write back only what a coherent agent has modified
                            if (cache_dirty_i) begin
                                cmd_next = CBO_CMD_WB; // RL15
                            end else if (after_clean_done) begin
                                state_next = CBO_ST_DONE; // RL15
                            end else begin
                                cmd_next = after_clean_cmd;
                            end
                        end
                        CBO_CMD_WB: begin
                            wb_next = 1'b1;
                            if (after_clean_done) begin
                                state_next = CBO_ST_DONE;
                            end else begin
                                cmd_next = after_clean_cmd; // RL14
                            end
                        end
                        CBO_CMD_ZERO: begin
                            // one word per beat; the block is not zeroed atomically
                            if (beat_last) begin
                                state_next = CBO_ST_DONE; // RL8
                            end else begin
                                addr_next = blk_reg + beat_off + XLEN'(WORD_BYTES); // RL7
                            end
                        end
                        default: begin
                            state_next = CBO_ST_DONE;
                        end
                    endcase
                end
            end
            CBO_ST_DONE: begin
                if (en_i) begin
                    state_next = CBO_ST_IDLE;
                end
            end
            default: begin
                state_next = CBO_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= CBO_ST_IDLE;
            op_reg <= CBO_NOP;
            cmd_reg <= CBO_CMD_PROBE;
            blk_reg <= '0;
            addr_reg <= '0;
            wb_reg <= 1'b0;
        end else if (en_i) begin
            state_reg <= state_next;
            op_reg <= op_next;
            cmd_reg <= cmd_next;
            blk_reg <= blk_next;
            addr_reg <= addr_next;
            wb_reg <= wb_next;
        end
    end

    // commands go only to this agent's own coherent hierarchy
    assign cache_cmd_valid_o = (state_reg == CBO_ST_ISSUE); // RL3
    assign cache_cmd_o = cmd_reg;
    assign cache_addr_o = addr_reg;
    // the lock keeps other agents off the block between the clean and the invalidate
    assign cache_lock_o = (op_reg == CBO_FLUSH) &&
                          (state_reg == CBO_ST_ISSUE || state_reg == CBO_ST_WAIT); // RL14

    assign done_o = (state_reg == CBO_ST_DONE) && en_i;
    assign done_op_o = op_reg;
    assign done_addr_o = blk_reg;
    assign done_wb_o = wb_reg;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    a_clean_no_offset: assert property ( // RL1
        accept && req_op_i == CBO_CLEAN |=> blk_reg == {req_base_i[XLEN-1:$clog2(BLOCK_BYTES)],
            {$clog2(BLOCK_BYTES){1'b0}}} && op_reg == CBO_CLEAN)
        else $error("clean block address is not the aligned base");
    a_prefetch_addr_sum: assert property ( // RL9
        accept && req_op_i == CBO_PF_R && req_rd_i == `CBO_RD_ZERO |=>
        blk_reg == (($past(req_base_i) + {{(XLEN-`CBO_IMM_W){$past(req_imm_hi_i[`CBO_IMM_HI_W-1])}},
            $past(req_imm_hi_i), `CBO_RD_ZERO}) & ~XLEN'(BLOCK_BYTES - 1)))
        else $error("prefetch block address is not base plus offset");
    a_pf_rd_nonzero: assert property ( // RL16
        accept && req_op_i == CBO_PF_W && req_rd_i != `CBO_RD_ZERO |=> state_reg == CBO_ST_DONE)
        else $error("prefetch with nonzero destination touched the caches");
    a_inval_to_flush: assert property ( // RL13
        accept && req_op_i == CBO_INVAL && req_priv_i == CBO_PRIV_U &&
        senv_invalidate_behaviour_field_i == `CBO_INVB_FLUSH |=> op_reg == CBO_FLUSH)
        else $error("invalidate not turned into flush");
    a_inval_m_stays: assert property ( // RL5
        accept && req_op_i == CBO_INVAL && req_priv_i == CBO_PRIV_M |=>
        op_reg == CBO_INVAL && cmd_reg == CBO_CMD_INVAL)
        else $error("machine-mode invalidate changed its kind");
    a_flush_locked: assert property ( // RL14
        op_reg == CBO_FLUSH && cache_cmd_valid_o |-> cache_lock_o)
        else $error("flush command issued without the lock");
    a_clean_skip_wb: assert property ( // RL15
        acked && cmd_reg == CBO_CMD_PROBE && !cache_dirty_i && op_reg == CBO_CLEAN |=>
        state_reg == CBO_ST_DONE && !done_wb_o)
        else $error("clean of an unmodified block wrote back");
    a_flush_ends_inval: assert property ( // RL4
        acked && cmd_reg == CBO_CMD_WB && op_reg == CBO_FLUSH |=>
        cache_cmd_valid_o && cache_cmd_o == CBO_CMD_INVAL && cache_addr_o == blk_reg)
        else $error("flush did not invalidate after write-back");
    a_zero_beat_addr: assert property ( // RL7
        cache_cmd_valid_o && cache_cmd_o == CBO_CMD_ZERO |-> cache_addr_o == blk_reg + beat_off)
        else $error("zero beat address out of step");
    a_block_aligned: assert property ( // RL17
        state_reg != CBO_ST_IDLE |-> blk_reg[$clog2(BLOCK_BYTES)-1:0] == '0)
        else $error("block address not aligned");
    a_cmd_hold: assert property ( // RL3
        cache_cmd_valid_o && !cache_cmd_ready_i |=> cache_cmd_valid_o && $stable(cache_cmd_o))
        else $error("command dropped before taken");
    a_done_pulse: assert property (
        done_o |=> !done_o && req_ready_o)
        else $error("completion longer than one cycle");

    c_flush_dirty: cover property (acked && cmd_reg == CBO_CMD_WB && op_reg == CBO_FLUSH);
    c_zero_done: cover property (done_o && done_op_o == CBO_ZERO);
    c_prefetch_fill: cover property (acked && cmd_reg == CBO_CMD_FILL_I);
    wire logic a_cover_inval;
    assign a_cover_inval = accept && req_op_i == CBO_INVAL && ea_bus.eff_op == CBO_FLUSH;
    c_inval_flush: cover property (a_cover_inval);
endmodule // cbo_unit

`default_nettype wire

// ### dv/cbo_cache_model.sv
// behavioural coherent cache hierarchy that answers the unit's commands
`timescale 1ns/1ps
`default_nettype none

module cbo_cache_model
    import cbo_pkg::*;
#(
    parameter int XLEN = 64
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic en_i,
    // behaviour control
    input wire logic slow_i,
    input wire logic dirty_i,
    // command channel
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire cbo_cmd_t cmd_i,
    input wire logic [XLEN-1:0] addr_i,
    input wire logic lock_i,
    output logic ack_o,
    output logic dirty_o
);
    cbo_cmd_t log_cmd [0:255];
    logic [XLEN-1:0] log_addr [0:255];
    logic log_lock [0:255];
    int n_log;
    logic phase_reg;
    logic busy_reg;
    logic [1:0] wait_reg;
    wire logic take_w = cmd_valid_i && cmd_ready_o && en_i;

    // a slow hierarchy refuses every other cycle and answers late
    assign cmd_ready_o = !busy_reg && (!slow_i || phase_reg);
    // dirtiness means nothing outside ack, so show the opposite there
    assign dirty_o = ack_o ? dirty_i : !dirty_i;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_reg <= 1'b0;
            busy_reg <= 1'b0;
            wait_reg <= 2'h0;
            ack_o <= 1'b0;
            n_log <= 0;
        end else begin
            phase_reg <= !phase_reg;
            ack_o <= 1'b0;
            if (take_w) begin
                busy_reg <= 1'b1;
                wait_reg <= slow_i ? 2'h3 : 2'h0;
                log_cmd[n_log[7:0]] <= cmd_i;
                log_addr[n_log[7:0]] <= addr_i;
                log_lock[n_log[7:0]] <= lock_i;
                n_log <= n_log + 1;
            end else if (busy_reg) begin
                if (wait_reg == 2'h0) begin
                    ack_o <= 1'b1;
                    busy_reg <= 1'b0;
                end else begin
                    wait_reg <= wait_reg - 2'h1;
                end
            end
        end
    end
endmodule // cbo_cache_model

`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the cache block operation unit
`timescale 1ns/1ps
`default_nettype none
`include "cbo_defines.svh"

module testbench;
    import cbo_pkg::*;
    localparam logic [63:0] MASK = ~(64'(`CBO_BLOCK_BYTES) - 64'h1);
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_valid_i = 1'b0;
    cbo_op_t req_op_i = CBO_NOP;
    logic [63:0] req_base_i = 64'h0;
    logic [6:0] req_imm_hi_i = 7'h00;
    logic [4:0] req_rd_i = 5'h00;
    cbo_priv_t req_priv_i = CBO_PRIV_M;
    logic [1:0] invb_m = 2'h0;
    logic [1:0] invb_s = 2'h0;
    logic [1:0] invb_h = 2'h0;
    logic slow = 1'b0;
    logic dirty = 1'b0;
    logic req_ready_o;
    logic done_o;
    cbo_op_t done_op_o;
    logic [63:0] done_addr_o;
    logic done_wb_o;
    logic cmd_valid;
    logic cmd_ready;
    cbo_cmd_t cmd;
    logic [63:0] cmd_addr;
    logic cache_lock_o;
    logic ack;
    logic ack_dirty;
    int fails = 0;
    int n_tests = 0;
    cbo_cmd_t exp_cmd [0:15];
    logic [63:0] exp_addr [0:15];
    int exp_n;
    int base_n;
    cbo_op_t got_op;
    logic [63:0] got_addr;
    logic got_wb;

    always #5 clock_i = ~clock_i;

    cbo_unit i_cbo_unit (
        .clock_i(clock_i), .nrst_i(nrst_i), .en_i(1'b1),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i),
        .req_base_i(req_base_i), .req_imm_hi_i(req_imm_hi_i), .req_rd_i(req_rd_i), .req_priv_i(req_priv_i),
        .menv_invalidate_behaviour_field_i(invb_m), .senv_invalidate_behaviour_field_i(invb_s),
        .henv_invalidate_behaviour_field_i(invb_h),
        .done_o(done_o), .done_op_o(done_op_o), .done_addr_o(done_addr_o), .done_wb_o(done_wb_o),
        .cache_cmd_valid_o(cmd_valid), .cache_cmd_ready_i(cmd_ready), .cache_cmd_o(cmd),
        .cache_addr_o(cmd_addr), .cache_lock_o(cache_lock_o), .cache_ack_i(ack), .cache_dirty_i(ack_dirty)
    );

    cbo_cache_model i_cbo_cache_model (
        .clock_i(clock_i), .nrst_i(nrst_i), .en_i(1'b1), .slow_i(slow), .dirty_i(dirty),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_i(cmd), .addr_i(cmd_addr),
        .lock_i(cache_lock_o), .ack_o(ack), .dirty_o(ack_dirty)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic push(input cbo_cmd_t c, input logic [63:0] a);
        exp_cmd[exp_n] = c;
        exp_addr[exp_n] = a;
        exp_n++;
    endtask

    // called at a falling edge; holds the request until taken, then waits for done
    task automatic run(input cbo_op_t op, input logic [63:0] b, input logic [6:0] ih, input logic [4:0] rd,
                       input cbo_priv_t pv);
        int k;
        k = 0;
        base_n = i_cbo_cache_model.n_log;
        req_op_i = op;
        req_base_i = b;
        req_imm_hi_i = ih;
        req_rd_i = rd;
        req_priv_i = pv;
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1 && k < 200) begin
            @(negedge clock_i);
            k++;
        end
        @(negedge clock_i);
        req_valid_i = 1'b0;
        while (done_o !== 1'b1 && k < 400) begin
            @(negedge clock_i);
            k++;
        end
        if (k >= 400) begin
            fails++;
            $display("[FAIL] %0t request never completed", $time);
            end_sim();
        end
        got_op = done_op_o;
        got_addr = done_addr_o;
        got_wb = done_wb_o;
        @(negedge clock_i);
    endtask

    task automatic chk_cmds(input logic lk);
        chk(i_cbo_cache_model.n_log - base_n == exp_n, "command count");
        for (int i = 0; i < exp_n; i++) begin
            chk(i_cbo_cache_model.log_cmd[base_n + i] === exp_cmd[i], "command kind");
            chk(i_cbo_cache_model.log_addr[base_n + i] === exp_addr[i], "command address");
            chk(i_cbo_cache_model.log_lock[base_n + i] === lk, "lock level during command");
        end
    endtask

    task automatic t_clean();
        logic [63:0] b;
        b = 64'h0000_1234_5678_9a7b;
        for (int d = 0; d < 2; d++) begin
            dirty = d[0];
            exp_n = 0;
            push(CBO_CMD_PROBE, b & MASK);
            if (d == 1) push(CBO_CMD_WB, b & MASK);
            run(CBO_CLEAN, b, 7'h00, 5'h00, CBO_PRIV_U);
            chk_cmds(1'b0);
            chk(got_op === CBO_CLEAN && got_addr === (b & MASK), "clean result");
            chk(got_wb === d[0], "clean write-back flag");
        end
        $display("test clean done");
    endtask

    task automatic t_flush();
        logic [63:0] b;
        b = 64'h0000_0000_0040_003f;
        dirty = 1'b1;
        slow = 1'b1;
        exp_n = 0;
        push(CBO_CMD_PROBE, b & MASK);
        push(CBO_CMD_WB, b & MASK);
        push(CBO_CMD_INVAL, b & MASK);
        run(CBO_FLUSH, b, 7'h00, 5'h00, CBO_PRIV_S);
        chk_cmds(1'b1);
        chk(got_op === CBO_FLUSH && got_wb === 1'b1 && got_addr === (b & MASK), "flush result");
        chk(cache_lock_o === 1'b0, "lock held after flush");
        slow = 1'b0;
        dirty = 1'b0;
        $display("test flush done");
    endtask

    task automatic t_inval();
        cbo_priv_t pv [7] = '{CBO_PRIV_M, CBO_PRIV_S, CBO_PRIV_S, CBO_PRIV_U, CBO_PRIV_VS, CBO_PRIV_VU, CBO_PRIV_VU};
        logic [5:0] fl [7] = '{6'h15, 6'h10, 6'h05, 6'h04, 6'h01, 6'h04, 6'h00};
        logic [63:0] b;
        logic fx;
        for (int i = 0; i < 7; i++) begin
            b = 64'h0000_0000_2000_0005 + 64'(i) * 64'h40;
            invb_m = fl[i][5:4];
            invb_s = fl[i][3:2];
            invb_h = fl[i][1:0];
            fx = (pv[i] != CBO_PRIV_M && invb_m == 2'h1) || (pv[i] == CBO_PRIV_U && invb_s == 2'h1)
                || (pv[i] == CBO_PRIV_VS && invb_h == 2'h1)
                || (pv[i] == CBO_PRIV_VU && (invb_h == 2'h1 || invb_s == 2'h1));
            exp_n = 0;
            if (fx) push(CBO_CMD_PROBE, b & MASK);
            push(CBO_CMD_INVAL, b & MASK);
            run(CBO_INVAL, b, 7'h00, 5'h00, pv[i]);
            chk_cmds(fx);
            chk(got_op === (fx ? CBO_FLUSH : CBO_INVAL) && got_addr === (b & MASK), "invalidate performed as");
        end
        $display("test invalidate done");
    endtask

    task automatic t_zero();
        logic [63:0] b;
        b = 64'h8000_0000_0000_0127;
        exp_n = 0;
        for (int i = 0; i < `CBO_BLOCK_BYTES / `CBO_WORD_BYTES; i++)
            push(CBO_CMD_ZERO, (b & MASK) + 64'(i * `CBO_WORD_BYTES));
        run(CBO_ZERO, b, 7'h00, 5'h00, CBO_PRIV_M);
        chk_cmds(1'b0);
        chk(got_op === CBO_ZERO && got_addr === (b & MASK), "zero result");
        $display("test zero done");
    endtask

    task automatic t_prefetch();
        cbo_op_t ops [3] = '{CBO_PF_I, CBO_PF_R, CBO_PF_W};
        cbo_cmd_t cmds [3] = '{CBO_CMD_FILL_I, CBO_CMD_FILL_R, CBO_CMD_FILL_W};
        logic [6:0] ihs [3] = '{7'h7f, 7'h01, 7'h40};
        logic [63:0] b;
        logic [63:0] a;
        b = 64'h0000_0000_0001_0010;
        for (int i = 0; i < 3; i++) begin
            a = (b + {{52{ihs[i][6]}}, ihs[i], 5'h00}) & MASK;
            exp_n = 0;
            push(cmds[i], a);
            run(ops[i], b, ihs[i], 5'h00, CBO_PRIV_U);
            chk_cmds(1'b0);
            chk(got_op === ops[i] && got_addr === a, "prefetch result");
        end
        $display("test prefetch done");
    endtask

    task automatic t_badpf();
        exp_n = 0;
        run(CBO_PF_W, 64'h0000_0000_0000_1000, 7'h01, 5'h04, CBO_PRIV_U);
        chk_cmds(1'b0);
        chk(got_op === CBO_NOP, "prefetch with nonzero destination");
        $display("test bad prefetch done");
    endtask

    initial begin
        repeat (4) @(negedge clock_i);
        nrst_i = 1'b1;
        @(negedge clock_i);
        t_clean();
        t_flush();
        t_inval();
        t_zero();
        t_prefetch();
        t_badpf();
        end_sim();
    end
endmodule // testbench

`default_nettype wire

// ### shared/cbo_defines.svh
// constants for the cache block operation unit
`ifndef CBO_DEFINES_SVH
`define CBO_DEFINES_SVH

`define CBO_XLEN 64
`define CBO_BLOCK_BYTES 64
`define CBO_WORD_BYTES 8
`define CBO_IMM_W 12
`define CBO_IMM_LO_W 5
`define CBO_IMM_HI_W 7
`define CBO_INVB_W 2
`define CBO_INVB_FLUSH 2'h1
`define CBO_RD_ZERO 5'h00

`endif

// ### shared/cbo_ea_if.sv
// request fields in, effective operation and block address out
`timescale 1ns/1ps
`default_nettype none
`include "cbo_defines.svh"

interface cbo_ea_if
    import cbo_pkg::*;
#(
    parameter int XLEN = `CBO_XLEN
);
    cbo_op_t op;
    logic [XLEN-1:0] base;
    logic [`CBO_IMM_HI_W-1:0] imm_hi;
    logic [`CBO_IMM_LO_W-1:0] rd;
    cbo_priv_t priv;
    logic [`CBO_INVB_W-1:0] menv_invb;
    logic [`CBO_INVB_W-1:0] senv_invb;
    logic [`CBO_INVB_W-1:0] henv_invb;
    cbo_op_t eff_op;
    logic [XLEN-1:0] blk_addr;

    modport user (
        output op, base, imm_hi, rd, priv, menv_invb, senv_invb, henv_invb,
        input eff_op, blk_addr
    );
    modport agen (
        input op, base, imm_hi, rd, priv, menv_invb, senv_invb, henv_invb,
        output eff_op, blk_addr
    );
endinterface

`default_nettype wire

// ### shared/cbo_pkg.sv
// types for the cache block operation unit
package cbo_pkg;

    // operation requested by the pipeline, and as finally performed
    typedef enum logic [2:0] {
        CBO_CLEAN,
        CBO_FLUSH,
        CBO_INVAL,
        CBO_ZERO,
        CBO_PF_I,
        CBO_PF_R,
        CBO_PF_W,
        CBO_NOP
    } cbo_op_t;

    // command sent into the coherent cache hierarchy
    typedef enum logic [2:0] {
        CBO_CMD_PROBE,
        CBO_CMD_WB,
        CBO_CMD_INVAL,
        CBO_CMD_ZERO,
        CBO_CMD_FILL_I,
        CBO_CMD_FILL_R,
        CBO_CMD_FILL_W
    } cbo_cmd_t;

    typedef enum logic [2:0] {
        CBO_PRIV_M,
        CBO_PRIV_S,
        CBO_PRIV_U,
        CBO_PRIV_VS,
        CBO_PRIV_VU
    } cbo_priv_t;

endpackage
